/* File: core/vfr_delay_timer.sv */
/*
 * delay timer: counts 2**code time units of unit_cycles clocks each,
 * and raises done for one cycle, during the last counting cycle.
 * assumes start comes from logic on the same clock; a start while busy reloads.
 */
`timescale 1ns/1ps
module vfr_delay_timer (
   // clock and reset
   input wire logic clk_in,
   input wire logic nrst_in,
   // control
   input wire logic start_in,
   input wire logic [2:0] code_in,
   input wire logic [15:0] unit_cycles_in,
   // status
   output logic busy_out,
   output logic done_out
);
   import vfr_pkg::*;

   vfr_tmr_t st_r;
   vfr_tmr_t st_nxt;
   logic [15:0] unit_m1;

   // a zero unit length is taken as one cycle so the timer always ends
   assign unit_m1 = (unit_cycles_in == 16'h0000) ? 16'h0000 : 16'(unit_cycles_in - 16'h0001);

   always_comb begin
      st_nxt = st_r;
      if (start_in) begin
         st_nxt.busy = 1'b1;
         st_nxt.units = vfr_units_m1(code_in);
         st_nxt.cyc = unit_m1;
      end else if (st_r.busy) begin
         if (st_r.cyc == 16'h0000) begin
            if (st_r.units == 8'h00) begin
               st_nxt.busy = 1'b0;
            end else begin
               st_nxt.units = 8'(st_r.units - 8'h01);
               st_nxt.cyc = unit_m1;
            end
         end else begin
            st_nxt.cyc = 16'(st_r.cyc - 16'h0001);
         end
      end
      // done flags the last busy cycle, so a restart loaded on the next edge adds no extra clock
      st_nxt.done = st_nxt.busy && st_nxt.cyc == 16'h0000 && st_nxt.units == 8'h00;
   end

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign busy_out = st_r.busy;
   assign done_out = st_r.done;

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!nrst_in);

   property p_units_load;
      start_in |=> st_r.busy && st_r.units == vfr_units_m1($past(code_in));
   endproperty
   a_units_load: assert property (p_units_load) else $error("delay unit count not loaded as power of two");

   property p_unit_len;
      start_in && unit_cycles_in == 16'h0003 |=> st_r.cyc == 16'h0002;
   endproperty
   a_unit_len: assert property (p_unit_len) else $error("unit length not taken from time unit input");

endmodule : vfr_delay_timer

/* File: core/vfr_pkg.sv */
/*
 * shared constants and types for the output-voltage supervision block:
 * command codes, response byte fields, reset values, states and register images.
 * assumes a single 100 MHz clock domain for everything that imports it.
 */
package vfr_pkg;

   // command codes of the limit words and the response byte
   localparam logic [7:0] CMD_OV_WARN = 8'h42;
   localparam logic [7:0] CMD_UV_WARN = 8'h43;
   localparam logic [7:0] CMD_UV_FAULT = 8'h44;
   localparam logic [7:0] CMD_UV_RESP = 8'h45;

   // response byte fields
   localparam int RESP_MODE_HI = 7;
   localparam int RESP_MODE_LO = 6;
   localparam int RESP_RETRY_HI = 5;
   localparam int RESP_RETRY_LO = 3;
   localparam int RESP_DLY_HI = 2;
   localparam int RESP_DLY_LO = 0;

   localparam logic [1:0] MODE_IGNORE = 2'h0;
   localparam logic [1:0] MODE_RUN_DELAY = 2'h1;
   localparam logic [1:0] MODE_OFF_RETRY = 2'h2;
   localparam logic [1:0] MODE_OFF_HOLD = 2'h3;
   localparam logic [2:0] RETRY_NONE = 3'h0;
   localparam logic [2:0] RETRY_FOREVER = 3'h7;

   // reset values
   localparam logic [15:0] OV_WARN_RST = 16'hffff;
   localparam logic [15:0] UV_WARN_RST = 16'h0000;
   localparam logic [15:0] UV_FAULT_RST = 16'h0000;
   localparam logic [7:0] RESP_RST = 8'h80;

   // synchroniser lanes
   localparam int SYNC_W = 3;
   localparam int SYNC_ON = 0;
   localparam int SYNC_BIAS = 1;
   localparam int SYNC_OTHER = 2;

   typedef enum logic [2:0] {
      ST_SHUT, ST_RUN, ST_DELAY, ST_OFF_WAIT, ST_ATTEMPT, ST_HOLD, ST_LATCHED
   } vfr_state_t;

   typedef struct packed {
      logic busy;
      logic done;
      logic [7:0] units;
      logic [15:0] cyc;
   } vfr_tmr_t;

   typedef struct packed {
      vfr_state_t fsm;
      logic [2:0] tries;
      logic [15:0] ov_lim;
      logic [15:0] uvw_lim;
      logic [15:0] uvf_lim;
      logic [7:0] resp;
      logic ov_warn;
      logic uv_warn;
      logic uv_fault;
      logic [SYNC_W-1:0] s1;
      logic [SYNC_W-1:0] s2;
      logic [15:0] rdata;
      logic rvalid;
      logic nack;
      logic attempt;
   } vfr_regs_t;

   // units remaining minus one for a delay code: 2**code units in all
   function automatic logic [7:0] vfr_units_m1(input logic [2:0] code);
      return 8'((9'h001 << code) - 9'h001);
   endfunction : vfr_units_m1

endpackage : vfr_pkg

/* File: core/vfr_top.sv */
/*
 * output-voltage supervision: three 16-bit limit words, the under-voltage
 * fault response byte, limit comparators and the retry / delay sequencer.
 * assumes a command decoder on the same clock presents one word transfer per
 * strobe, and that measurement and time unit come from same-clock logic.
 * the control, bias and other-fault levels arrive from pins and are synchronised.
 */
`timescale 1ns/1ps

module vfr_top (
   // clock and reset
   input wire logic clk_in,
   input wire logic nrst_in,
   // command port
   input wire logic [7:0] cmd_in,
   input wire logic wr_in,
   input wire logic rd_in,
   input wire logic [15:0] wdata_in,
   output logic [15:0] rdata_out,
   output logic rvalid_out,
   output logic nack_out,
   // measurement and time base
   input wire logic [15:0] vout_meas_in,
   input wire logic [15:0] unit_cycles_in,
   // on/off and fault sources
   input wire logic on_cmd_in,
   input wire logic bias_ok_in,
   input wire logic other_fault_in,
   input wire logic clear_faults_in,
   // status
   output logic ov_warn_out,
   output logic uv_warn_out,
   output logic uv_fault_out,
   output logic out_enable_out,
   output logic attempt_out,
   output logic latched_off_out
);
   import vfr_pkg::*;

   vfr_regs_t st_r;
   vfr_regs_t st_nxt;
   logic t_start;
   logic t_done;
   logic t_busy;
   logic [1:0] mode;
   logic [2:0] retries;
   logic [2:0] dly_code;
   logic stop;
   logic fault;
   logic [SYNC_W-1:0] pins;

   assign mode = st_r.resp[RESP_MODE_HI:RESP_MODE_LO];
   assign retries = st_r.resp[RESP_RETRY_HI:RESP_RETRY_LO];
   assign dly_code = st_r.resp[RESP_DLY_HI:RESP_DLY_LO];
   assign fault = st_r.uv_fault;
   assign pins = {other_fault_in, bias_ok_in, on_cmd_in};
   assign stop = !st_r.s2[SYNC_ON] || !st_r.s2[SYNC_BIAS] || st_r.s2[SYNC_OTHER];

   vfr_delay_timer u_timer (
      .clk_in(clk_in),
      .nrst_in(nrst_in),
      .start_in(t_start),
      .code_in(dly_code),
      .unit_cycles_in(unit_cycles_in),
      .busy_out(t_busy),
      .done_out(t_done)
   );

   always_comb begin
      st_nxt = st_r;
      t_start = 1'b0;
      st_nxt.s1 = pins;
      st_nxt.s2 = st_r.s1;
      st_nxt.rvalid = 1'b0;
      st_nxt.nack = 1'b0;
      st_nxt.attempt = 1'b0;

      st_nxt.ov_warn = vout_meas_in > st_r.ov_lim;
      st_nxt.uv_warn = vout_meas_in < st_r.uvw_lim;
      st_nxt.uv_fault = vout_meas_in < st_r.uvf_lim;

      // whole-word transfers only; the response byte uses the low lane
      if (wr_in) begin
         case (cmd_in)
            CMD_OV_WARN: st_nxt.ov_lim = wdata_in;
            CMD_UV_WARN: st_nxt.uvw_lim = wdata_in;
            CMD_UV_FAULT: st_nxt.uvf_lim = wdata_in;
            CMD_UV_RESP: st_nxt.resp = wdata_in[7:0];
            default: st_nxt.nack = 1'b1;
         endcase
      end else if (rd_in) begin
         st_nxt.rvalid = 1'b1;
         case (cmd_in)
            CMD_OV_WARN: st_nxt.rdata = st_r.ov_lim;
            CMD_UV_WARN: st_nxt.rdata = st_r.uvw_lim;
            CMD_UV_FAULT: st_nxt.rdata = st_r.uvf_lim;
            CMD_UV_RESP: st_nxt.rdata = {8'h00, st_r.resp};
            default: begin
               st_nxt.rdata = 16'h0000;
               st_nxt.rvalid = 1'b0;
               st_nxt.nack = 1'b1;
            end
         endcase
      end

      if (stop) begin
         // a commanded off, bias loss or foreign fault ends any sequence
         st_nxt.fsm = ST_SHUT;
         st_nxt.tries = 3'h0;
      end else begin
         case (st_r.fsm)
            ST_SHUT: st_nxt.fsm = ST_RUN;
            ST_RUN: begin
               if (fault) begin
                  case (mode)
                     MODE_RUN_DELAY: begin
                        st_nxt.fsm = ST_DELAY;
                        t_start = 1'b1;
                     end
                     MODE_OFF_RETRY: begin
                        if (retries == RETRY_NONE) begin
                           st_nxt.fsm = ST_LATCHED;
                        end else begin
                           st_nxt.fsm = ST_OFF_WAIT;
                           t_start = 1'b1;
                        end
                     end
                     MODE_OFF_HOLD: st_nxt.fsm = ST_HOLD;
                     default: st_nxt.fsm = ST_RUN;
                  endcase
               end
            end
            ST_DELAY: begin
               // run-on time ended: a fault still present falls to the retry setting
               if (t_done) begin
                  if (!fault) begin
                     st_nxt.fsm = ST_RUN;
                  end else if (retries == RETRY_NONE) begin
                     st_nxt.fsm = ST_LATCHED;
                  end else begin
                     st_nxt.fsm = ST_OFF_WAIT;
                     t_start = 1'b1;
                  end
               end
            end
            ST_OFF_WAIT: begin
               if (t_done) begin
                  st_nxt.fsm = ST_ATTEMPT;
                  st_nxt.tries = 3'h1;
                  st_nxt.attempt = 1'b1;
                  t_start = 1'b1;
               end
            end
            ST_ATTEMPT: begin
               // each attempt is judged one delay after it started
               if (t_done) begin
                  if (!fault) begin
                     st_nxt.fsm = ST_RUN;
                     st_nxt.tries = 3'h0;
                  end else if (retries != RETRY_FOREVER && st_r.tries >= retries) begin
                     st_nxt.fsm = ST_LATCHED;
                  end else begin
                     st_nxt.attempt = 1'b1;
                     t_start = 1'b1;
                     if (retries != RETRY_FOREVER) begin
                        st_nxt.tries = st_r.tries + 3'h1;
                     end
                  end
               end
            end
            ST_HOLD: begin
               if (!fault) begin
                  st_nxt.fsm = ST_RUN;
               end
            end
            ST_LATCHED: begin
               if (clear_faults_in) begin
                  st_nxt.fsm = ST_RUN;
                  st_nxt.tries = 3'h0;
               end
            end
            default: st_nxt.fsm = ST_SHUT;
         endcase
      end
   end

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         st_r.fsm <= ST_SHUT;
         st_r.tries <= 3'h0;
         st_r.ov_lim <= OV_WARN_RST;
         st_r.uvw_lim <= UV_WARN_RST;
         st_r.uvf_lim <= UV_FAULT_RST;
         st_r.resp <= RESP_RST;
         st_r.ov_warn <= 1'b0;
         st_r.uv_warn <= 1'b0;
         st_r.uv_fault <= 1'b0;
         st_r.s1 <= '0;
         st_r.s2 <= '0;
         st_r.rdata <= 16'h0000;
         st_r.rvalid <= 1'b0;
         st_r.nack <= 1'b0;
         st_r.attempt <= 1'b0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign rdata_out = st_r.rdata;
   assign rvalid_out = st_r.rvalid;
   assign nack_out = st_r.nack;
   assign ov_warn_out = st_r.ov_warn;
   assign uv_warn_out = st_r.uv_warn;
   assign uv_fault_out = st_r.uv_fault;
   assign attempt_out = st_r.attempt;
   assign latched_off_out = (st_r.fsm == ST_LATCHED);
   assign out_enable_out = (st_r.fsm == ST_RUN) || (st_r.fsm == ST_DELAY) || (st_r.fsm == ST_ATTEMPT);

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!nrst_in);

   property p_retry_cap;
      st_r.fsm == ST_ATTEMPT && retries != RETRY_FOREVER |-> st_r.tries <= retries;
   endproperty
   a_retry_cap: assert property (p_retry_cap) else $error("more restarts than the retry field allows");

   property p_attempt_timer;
      attempt_out |-> t_busy && $past(t_done);
   endproperty
   a_attempt_timer: assert property (p_attempt_timer) else $error("restart not spaced by the delay timer");

   property p_forever;
      st_r.fsm == ST_ATTEMPT && retries == RETRY_FOREVER && t_done && fault && !stop
         |=> attempt_out && !latched_off_out;
   endproperty
   a_forever: assert property (p_forever) else $error("continuous retry stopped");

   property p_run_on;
      st_r.fsm == ST_RUN && fault && mode == MODE_RUN_DELAY && !stop |=> out_enable_out && t_busy;
   endproperty
   a_run_on: assert property (p_run_on) else $error("run-on delay not started with output on");

   property p_ov_word;
      wr_in && cmd_in == CMD_OV_WARN ##1 !wr_in ##1 rd_in && !wr_in && cmd_in == CMD_OV_WARN
         |=> rvalid_out && rdata_out == $past(wdata_in, 3);
   endproperty
   a_ov_word: assert property (p_ov_word) else $error("over-voltage warning word did not read back");

   property p_uvw_read;
      rd_in && !wr_in && cmd_in == CMD_UV_WARN |=> rvalid_out && rdata_out == $past(st_r.uvw_lim);
   endproperty
   a_uvw_read: assert property (p_uvw_read) else $error("under-voltage warning word read wrong");

   property p_uvf_write;
      wr_in && cmd_in == CMD_UV_FAULT |=> st_r.uvf_lim == $past(wdata_in) && !nack_out;
   endproperty
   a_uvf_write: assert property (p_uvf_write) else $error("under-voltage fault word not stored");

   property p_hold_off;
      st_r.fsm == ST_RUN && fault && mode == MODE_OFF_HOLD && !stop |=> !out_enable_out;
   endproperty
   a_hold_off: assert property (p_hold_off) else $error("hold mode left output on");

   property p_no_retry;
      st_r.fsm == ST_RUN && fault && mode == MODE_OFF_RETRY && retries == RETRY_NONE && !stop
         |=> latched_off_out && !attempt_out;
   endproperty
   a_no_retry: assert property (p_no_retry) else $error("retry code zero did not latch off");

   property p_ov_cmp;
      ##1 ov_warn_out == $past(vout_meas_in > st_r.ov_lim);
   endproperty
   a_ov_cmp: assert property (p_ov_cmp) else $error("over-voltage warning does not follow measurement");

   c_latch: cover property (st_r.fsm == ST_ATTEMPT ##1 latched_off_out);
   c_recover: cover property (st_r.fsm == ST_ATTEMPT ##1 st_r.fsm == ST_RUN);
   c_run_on: cover property (st_r.fsm == ST_DELAY ##1 st_r.fsm == ST_OFF_WAIT);
   c_hold: cover property (st_r.fsm == ST_HOLD ##1 st_r.fsm == ST_RUN);

endmodule : vfr_top

/* File: tb/vfr_host_model.sv */
/*
 * host model: moves whole 16-bit words over the command port of the supervision block.
 * assumes the device answers a read exactly one cycle after the strobe edge.
 */
`timescale 1ns/1ps
module vfr_host_model (
   // clock
   input wire logic clk_in,
   // command port
   output logic [7:0] cmd_out,
   output logic wr_out,
   output logic rd_out,
   output logic [15:0] wdata_out,
   input wire logic [15:0] rdata_in,
   input wire logic rvalid_in,
   input wire logic nack_in
);
   initial begin
      cmd_out = 8'h00;
      wr_out = 1'b0;
      rd_out = 1'b0;
      wdata_out = 16'h0000;
   end

   // strobes move on the falling edge so the rising edge sees them settled
   task automatic write_word(input logic [7:0] cmd, input logic [15:0] data);
      @(negedge clk_in);
      cmd_out = cmd;
      wdata_out = data;
      wr_out = 1'b1;
      @(negedge clk_in);
      wr_out = 1'b0;
      // stale data is not left standing on the bus
      wdata_out = ~data;
   endtask : write_word

   task automatic read_word(input logic [7:0] cmd, output logic [15:0] data, output logic nack);
      @(negedge clk_in);
      cmd_out = cmd;
      rd_out = 1'b1;
      @(negedge clk_in);
      rd_out = 1'b0;
      // a missing valid turns the word round so the compare cannot pass by luck
      data = rvalid_in ? rdata_in : ~rdata_in;
      nack = nack_in;
   endtask : read_word
endmodule : vfr_host_model

/* File: tb/vout_fault_limit_response_test.sv */
/*
 * self-checking bench for vfr_top: limit words, comparators and the retry sequencer.
 * assumes the host model drives the command port; other inputs change on falling edges.
 */
`timescale 1ns/1ps
module vout_fault_limit_response_test;
   import vfr_pkg::*;
   logic clk_in = 1'b0;
   logic nrst_in = 1'b0;
   logic [7:0] cmd;
   logic wr, rd, rvalid, nack, ovw, uvw, uvf, oen, att, lat;
   logic [15:0] wdata, rdata;
   logic [15:0] meas = 16'hf000;
   logic [15:0] unit = 16'h0002;
   logic clr = 1'b0;
   logic on_cmd = 1'b1;
   logic bias_ok = 1'b1;
   logic other = 1'b0;
   int bad_count = 0;
   int samples_checked = 0;
   int n_att = 0;
   int gap = 0;
   int exp_gap = 0;
   logic [31:0] seed = 32'ha40b;

   always #5 clk_in = ~clk_in;

   vfr_host_model host (.clk_in(clk_in), .cmd_out(cmd), .wr_out(wr), .rd_out(rd), .wdata_out(wdata),
      .rdata_in(rdata), .rvalid_in(rvalid), .nack_in(nack));
   vfr_top DUT (.clk_in(clk_in), .nrst_in(nrst_in), .cmd_in(cmd), .wr_in(wr), .rd_in(rd),
      .wdata_in(wdata), .rdata_out(rdata), .rvalid_out(rvalid), .nack_out(nack), .vout_meas_in(meas),
      .unit_cycles_in(unit), .on_cmd_in(on_cmd), .bias_ok_in(bias_ok), .other_fault_in(other),
      .clear_faults_in(clr), .ov_warn_out(ovw), .uv_warn_out(uvw), .uv_fault_out(uvf),
      .out_enable_out(oen), .attempt_out(att), .latched_off_out(lat));

   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] v;
      v = s ^ (s << 13);
      v = v ^ (v >> 17);
      return v ^ (v << 5);
   endfunction : xs

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic end_sim;
      $display("checks=%0d mismatches=%0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : end_sim

   task automatic cyc(input int n);
      repeat (n) @(negedge clk_in);
   endtask : cyc

   // bounded wait on the latch flag or the output enable
   task automatic wait_hi(input bit want_lat, input int lim);
      for (int i = 0; i < lim; i++) begin
         if ((want_lat ? lat : oen) === 1'b1) break;
         @(negedge clk_in);
      end
   endtask : wait_hi

   task automatic recover;
      meas = 16'hf000;
      clr = 1'b1;
      cyc(1);
      clr = 1'b0;
      wait_hi(1'b0, 40);
      check(16'(oen), 16'h0001);
   endtask : recover

   // attempts are timed start to start in clock cycles, on the falling edge where the pulse has settled
   always @(negedge clk_in) begin
      gap++;
      if (att === 1'b1) begin
         if (n_att > 0) check(16'(gap), 16'(exp_gap));
         n_att++;
         gap = 0;
      end
   end

   // budget is several times the longest expected run
   initial begin
      #(60000 * 10);
      bad_count++;
      $display("watchdog expired");
      end_sim();
   end

   initial begin
      logic [15:0] d;
      logic nk;
      logic [15:0] lim [3];
      int k0;
      repeat (20) @(posedge clk_in);
      @(negedge clk_in);
      nrst_in = 1'b1;
      for (int k = 0; k < 4; k++) begin
         host.read_word(8'h42 + 8'(k), d, nk);
         check(d, k == 0 ? OV_WARN_RST : k == 3 ? {8'h00, RESP_RST} : 16'h0000);
      end
      for (int k = 0; k < 12; k++) begin
         seed = xs(seed);
         host.write_word(8'h42 + 8'(k % 3), seed[15:0]);
         host.read_word(8'h42 + 8'(k % 3), d, nk);
         check(d, seed[15:0]);
         check(16'(nk), 16'h0000);
      end
      host.write_word(8'h46, 16'h1234);
      check(16'(nack), 16'h0001);
      host.read_word(8'h46, d, nk);
      check({d[14:0], nk}, 16'hffff);
      $display("done: limit words");
      host.write_word(CMD_UV_RESP, 16'h0000);
      for (int k = 0; k < 3; k++) begin
         seed = xs(seed);
         lim[k] = seed[15:0];
         host.write_word(8'h42 + 8'(k), lim[k]);
      end
      // every fourth sample sits exactly on a limit
      for (int k = 0; k < 24; k++) begin
         seed = xs(seed);
         meas = (k % 4 == 0) ? lim[k % 3] : seed[15:0];
         cyc(2);
         check(16'({ovw, uvw, uvf}), 16'({meas > lim[0], meas < lim[1], meas < lim[2]}));
         check(16'(oen), 16'h0001);
      end
      $display("done: comparators");
      host.write_word(CMD_UV_FAULT, 16'h8000);
      meas = 16'hf000;
      for (int r = 0; r < 7; r++) begin
         seed = xs(seed);
         unit = 16'(seed[1:0] % 3 + 1);
         exp_gap = (1 << r) * int'(unit);
         host.write_word(CMD_UV_RESP, {8'h00, MODE_OFF_RETRY, 3'(r), 3'(r)});
         n_att = 0;
         meas = 16'h1000;
         cyc(2);
         check(16'(oen), 16'h0000);
         wait_hi(1'b1, 2000);
         check(16'(n_att), 16'(r));
         cyc(3);
         check(16'({lat, oen}), 16'h0002);
         recover();
      end
      $display("done: counted retries");
      unit = 16'h0002;
      host.write_word(CMD_UV_RESP, {8'h00, MODE_RUN_DELAY, 3'h1, 3'h2});
      n_att = 0;
      meas = 16'h1000;
      cyc(6);
      check(16'(oen), 16'h0001);
      wait_hi(1'b1, 200);
      check(16'(n_att), 16'h0001);
      recover();
      host.write_word(CMD_UV_RESP, {8'h00, MODE_OFF_HOLD, 6'h00});
      meas = 16'h1000;
      cyc(3);
      check(16'({oen, lat}), 16'h0000);
      meas = 16'hf000;
      cyc(3);
      check(16'(oen), 16'h0001);
      $display("done: response modes");
      unit = 16'h0001;
      exp_gap = 128;
      host.write_word(CMD_UV_RESP, {8'h00, MODE_OFF_RETRY, RETRY_FOREVER, 3'h7});
      for (int s = 0; s < 3; s++) begin
         n_att = 0;
         meas = 16'h1000;
         cyc(1300);
         check(16'({n_att > 6, lat}), 16'h0002);
         {on_cmd, bias_ok, other} = 3'b110 ^ (3'b100 >> s);
         cyc(5);
         k0 = n_att;
         cyc(300);
         check(16'({oen, lat}), 16'h0000);
         check(16'(n_att), 16'(k0));
         meas = 16'hf000;
         {on_cmd, bias_ok, other} = 3'b110;
         wait_hi(1'b0, 40);
         check(16'(oen), 16'h0001);
      end
      $display("done: continuous retry");
      end_sim();
   end
endmodule : vout_fault_limit_response_test
